// ==== dv/phc_props.sv ====
// Checker of the link between the host controller and the printer device.
`timescale 1ns/1ps
module phc_props (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       dq_host_oe,
  input wire logic [7:0] dq_dev,
  input wire logic       dq_dev_oe,
  input wire logic       req_o_line,
  input wire logic       dma_req,
  input wire logic       dma_ack,
  input wire logic       dma_done
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_wr_drops_req: assert property ($fell(wr_n) && !cs_n |-> ##[1:6] !req_o_line)
    else $error("Request stayed high after a byte write.");
  a_req_no_dma: assert property (req_o_line |-> !dma_req)
    else $error("Request high while DMA still fetches.");
  a_req_full_clr: assert property (dq_dev_oe && req_o_line && $past(req_o_line) |-> !dq_dev[phc_pkg::FULL_BIT])
    else $error("Request high while status shows input full.");
  a_stat_drive: assert property (dq_dev_oe |-> !$past(cs_n, 3) && !$past(rd_n, 3))
    else $error("Device drove status without a read.");
  a_no_clash: assert property (!(dq_dev_oe && dq_host_oe))
    else $error("Both ends drive the data bus.");
  a_strobe_excl: assert property (!(!rd_n && !wr_n))
    else $error("Read and write strobes low together.");
  a_wr_width: assert property ($fell(wr_n) |-> !cs_n ##0 (!wr_n)[*5] ##1 wr_n)
    else $error("Write strobe width wrong.");
  a_dma_ack_pulse: assert property (dma_ack |-> dma_req ##1 !dma_ack)
    else $error("DMA acknowledge without request or too long.");
  a_done_idle: assert property (!dma_done)
    else $error("DMA done line asserted.");
endmodule

// ==== dv/testbench.sv ====
// Self-checking testbench of the printer host port, both ends joined.
`timescale 1ns/1ps
module testbench;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc   = 1'b0;
  logic        wb_stb   = 1'b0;
  logic        wb_we    = 1'b0;
  logic [3:0]  wb_adr   = 4'h0;
  logic [3:0]  wb_sel   = 4'h0;
  logic [31:0] wb_wdat  = 32'h0;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic [31:0] rd;
  logic        gp1, gp2, dens10, dbl, printing, feeding;
  logic [2:0]  strobe;
  logic [5:0]  fill;
  int          err_total = 0;
  int          n_checks  = 0;
  int          cycles    = 0;
  int          n_dma     = 0;
  int          i;

  // ---------------------------------------------------------------
  // Clock, watchdog and instances.
  // ---------------------------------------------------------------
  always #2.5 clk_i = ~clk_i;

  // Cuts a hang short and counts DMA byte strobes.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (link.dma_ack === 1'b1) n_dma <= n_dma + 1;
    if (cycles == 60000) begin
      err_total++;
      conclude();
    end
  end

  phc_if link();  // Parallel link only, strapped by the board
  phc_host u_phc_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .bus(link));
  phc_device #(.PRINT_CYC(200), .LF_CYC(100)) u_phc_device (.clk_i(clk_i), .rst_i(rst_i), .bus(link),
    .gp1_o(gp1), .gp2_o(gp2), .strobe_sel_o(strobe), .dens10_o(dens10), .double_o(dbl), .fill_o(fill),
    .printing_o(printing), .feeding_o(feeding));
  phc_props u_phc_props (.clk_i(clk_i), .rst_i(rst_i), .cs_n(link.cs_n), .rd_n(link.rd_n), .wr_n(link.wr_n),
    .dq_host_oe(link.dq_host_oe), .dq_dev(link.dq_dev), .dq_dev_oe(link.dq_dev_oe), .req_o_line(link.req_o_line),
    .dma_req(link.dma_req), .dma_ack(link.dma_ack), .dma_done(link.dma_done));

  // ---------------------------------------------------------------
  // Tasks.
  // ---------------------------------------------------------------
  // Compares two values and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle; read data lands in rd.
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= a;
    wb_sel  <= 4'hf;
    wb_wdat <= d;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  // Waits until the device may take another byte.
  task automatic wait_req();
    @(posedge clk_i);
    while (link.req_o_line !== 1'b1) @(posedge clk_i);
  endtask

  // Hands one byte to the device once it is ready for it.
  task automatic send(input logic [7:0] b);
    wait_req();
    wb(1'b1, phc_pkg::CTL_DATA_OFF, {24'h0, b});
  endtask

  // Reads device status and compares full and DMA flags.
  task automatic stat(input logic [1:0] exp);
    wb(1'b0, phc_pkg::CTL_STAT_OFF, 32'h0);
    chk({30'h0, rd[phc_pkg::FULL_BIT], rd[phc_pkg::DMA_BIT]}, {30'h0, exp});
  endtask

  // Waits a bounded time for a busy flag to rise.
  task automatic wait_busy(ref logic f);
    for (i = 0; i < 40 && f !== 1'b1; i++) @(posedge clk_i);
  endtask

  // Packs the device settings and buffer fill for one compare.
  function automatic logic [31:0] cfg();
    return {19'h0, gp1, gp2, strobe, dens10, dbl, fill};
  endfunction

  function automatic logic [31:0] ex(input logic g1, input logic g2, input logic [2:0] s, input logic d,
                                     input logic b, input logic [5:0] f);
    return {19'h0, g1, g2, s, d, b, f};
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_req();
    chk(cfg(), ex(1'b1, 1'b1, phc_pkg::STROBE_RST, 1'b0, 1'b0, 6'd0));
    stat(2'b00);
    wb(1'b0, 4'hc, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, phc_pkg::CTL_DATA_OFF, 32'h0);
    chk(rd, 32'h100);
    $display("test reset_state done");
    send(8'h41);
    send(8'h42);
    wait_req();
    chk(cfg(), ex(1'b1, 1'b1, 3'h3, 1'b0, 1'b0, 6'd2));
    stat(2'b00);
    stat(2'b00);
    chk({31'h0, link.req_o_line}, 32'h1);
    $display("test byte_entry done");
    send(phc_pkg::CMD_DENS_10);
    wait_req();
    chk(cfg(), ex(1'b1, 1'b1, 3'h3, 1'b1, 1'b0, 6'd0));
    send(8'h41);
    send(phc_pkg::CMD_DOUBLE);
    wait_req();
    chk(cfg(), ex(1'b1, 1'b1, 3'h3, 1'b1, 1'b1, 6'd0));
    repeat (phc_pkg::CAP_10_DOUBLE) send(8'h30);
    wait_busy(printing);
    chk({31'h0, printing}, 32'h1);
    wb(1'b1, phc_pkg::CTL_DATA_OFF, 32'h43);
    stat(2'b10);
    wait_req();
    chk(cfg(), ex(1'b1, 1'b1, 3'h3, 1'b1, 1'b1, 6'd1));
    $display("test buffer_print done");
    send(phc_pkg::CMD_GP1_CLR);
    send(phc_pkg::CMD_STROBE);
    send(8'h05);
    send(phc_pkg::CMD_SW_RESET);
    wait_req();
    chk(cfg(), ex(1'b0, 1'b1, 3'h5, 1'b0, 1'b0, 6'd0));
    send(phc_pkg::CMD_DENS_10);
    send(phc_pkg::CMD_STROBE);
    send(phc_pkg::CMD_SW_RESET);
    send(phc_pkg::CMD_GP1_SET);
    send(phc_pkg::CMD_GP2_CLR);
    wait_req();
    chk(cfg(), ex(1'b1, 1'b0, 3'h4, 1'b1, 1'b0, 6'd0));
    $display("test soft_reset done");
    send(phc_pkg::CMD_LINE_FEED);
    wait_busy(feeding);
    chk({31'h0, feeding}, 32'h1);
    wb(1'b1, phc_pkg::CTL_DATA_OFF, 32'h44);
    stat(2'b10);
    wait_req();
    stat(2'b00);
    send(phc_pkg::CMD_CR);
    wait_busy(printing);
    chk({31'h0, printing}, 32'h1);
    send(phc_pkg::CMD_MULTI_LF);
    send(8'h02);
    wait_busy(feeding);
    chk({31'h0, feeding}, 32'h1);
    send(phc_pkg::CMD_DENS_12);
    wait_req();
    chk(cfg(), ex(1'b1, 1'b0, 3'h4, 1'b0, 1'b0, 6'd0));
    $display("test line_feed done");
    wb(1'b1, phc_pkg::CTL_DMA_OFF, 32'h0100);
    send(phc_pkg::CMD_DMA_EN);
    send(8'h02);
    send(8'h01);
    wb(1'b0, phc_pkg::CTL_STAT_OFF, 32'h0);
    chk({31'h0, rd[phc_pkg::DMA_BIT]}, 32'h1);
    wait_req();
    stat(2'b00);
    chk(n_dma, 32'd258);
    wb(1'b0, phc_pkg::CTL_DMA_OFF, 32'h0);
    chk({16'h0, rd[15:0]}, 32'h0202);
    $display("test dma_block done");
    conclude();
  end
endmodule

// ==== pkg/phc_if.sv ====
// Interface joining the host controller and the printer device port.
`timescale 1ns/1ps
interface phc_if;
  logic       cs_n;        // Chip select, active low.
  logic       rd_n;        // Read strobe, active low.
  logic       wr_n;        // Write strobe, active low.
  logic [7:0] dq_host;     // Data driven by the host.
  logic       dq_host_oe;  // Host drives the data bus.
  logic [7:0] dq_dev;      // Data driven by the device.
  logic       dq_dev_oe;   // Device drives the data bus.
  logic       req_o_line;  // Service request, high when a byte may be written.
  logic       dma_req;     // Device asks for a DMA byte.
  logic       dma_ack;     // DMA controller strobes a byte on dq_host.
  logic       dma_done;    // DMA controller has no more bytes.

  modport host (output cs_n, output rd_n, output wr_n, output dq_host, output dq_host_oe,
                input dq_dev, input dq_dev_oe, input req_o_line, input dma_req,
                output dma_ack, output dma_done);
  modport dev  (input cs_n, input rd_n, input wr_n, input dq_host, input dq_host_oe,
                output dq_dev, output dq_dev_oe, output req_o_line, output dma_req,
                input dma_ack, input dma_done);
endinterface

// ==== pkg/phc_pkg.sv ====
// Package with the shared constants of the printer host port.
package phc_pkg;

  // ---------------------------------------------------------------
  // Wishbone register offsets of the host controller.
  // ---------------------------------------------------------------
  localparam logic [3:0] CTL_DATA_OFF   = 4'h0;  // Write queues one byte for the device.
  localparam logic [3:0] CTL_STAT_OFF   = 4'h4;  // Read shows the device status byte.
  localparam logic [3:0] CTL_DMA_OFF    = 4'h8;  // Write loads the memory start address.

  // ---------------------------------------------------------------
  // Status bit positions and command codes.
  // ---------------------------------------------------------------
  localparam int        FULL_BIT       = 1;      // Input-full flag.
  localparam int        DMA_BIT        = 0;      // DMA-active flag.
  localparam logic [7:0] CMD_GP1_CLR   = 8'h00;
  localparam logic [7:0] CMD_GP2_CLR   = 8'h01;
  localparam logic [7:0] CMD_GP1_SET   = 8'h02;
  localparam logic [7:0] CMD_GP2_SET   = 8'h03;
  localparam logic [7:0] CMD_SW_RESET  = 8'h04;
  localparam logic [7:0] CMD_DENS_10   = 8'h05;
  localparam logic [7:0] CMD_DENS_12   = 8'h06;
  localparam logic [7:0] CMD_DOUBLE    = 8'h07;
  localparam logic [7:0] CMD_DMA_EN    = 8'h08;
  localparam logic [7:0] CMD_LINE_FEED = 8'h0a;
  localparam logic [7:0] CMD_MULTI_LF  = 8'h0b;
  localparam logic [7:0] CMD_CR        = 8'h0d;
  localparam logic [7:0] CMD_TAB1      = 8'h0e;
  localparam logic [7:0] CMD_TAB2      = 8'h0f;
  localparam logic [7:0] CMD_TAB3      = 8'h10;
  localparam logic [7:0] CMD_STROBE    = 8'h12;
  localparam logic [7:0] PRINT_LO      = 8'h20;
  localparam logic [7:0] PRINT_HI      = 8'h5f;

  // ---------------------------------------------------------------
  // Reset values and line buffer limits.
  // ---------------------------------------------------------------
  localparam logic [2:0] STROBE_RST    = 3'h3;   // 320 us selection.
  localparam logic [5:0] CAP_12_SINGLE = 6'd40;
  localparam logic [5:0] CAP_12_DOUBLE = 6'd20;
  localparam logic [5:0] CAP_10_SINGLE = 6'd33;
  localparam logic [5:0] CAP_10_DOUBLE = 6'd17;

  // ---------------------------------------------------------------
  // Mechanical cycle times.
  // ---------------------------------------------------------------
  localparam longint CLK_HZ      = 200000000;
  localparam longint PRINT_MS    = 800;
  localparam longint LF_MS       = 200;
  localparam longint PRINT_CYC   = PRINT_MS * CLK_HZ / 1000;
  localparam longint LF_CYC      = LF_MS * CLK_HZ / 1000;

endpackage

// ==== verilog/phc_device.sv ====
// Printer device end of the parallel host port.
//
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - Soft reset: empty buffer, 12 cpi, single
// - Soft reset keeps strobe, tabs, outputs
// - Pending parameter swallows reset code
// - Hard reset: empty, outputs high, 320us
// - Board straps parallel mode
// - Two registers: data write, status read
// - Write sets full; acceptance clears it
// - Host writes only when full clear
// - DMA flag set until count done
// - Request high means full is clear
// - Print and feed cycles hold bytes untaken
// - DMA enable fetches counted bytes
// - Last DMA byte clears flag, raises request
// - Sixteen-bit count covers all bytes
// - Host loads DMA address first
// - Host decodes select, uses strobes
// - Capacity by density and width; full prints
// - DMA code takes low length byte first
// - Density or width change empties buffer
module phc_device #(
  parameter longint PRINT_CYC = phc_pkg::PRINT_CYC,
  parameter longint LF_CYC    = phc_pkg::LF_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  phc_if.dev              bus,
  output logic            gp1_o,
  output logic            gp2_o,
  output logic [2:0]      strobe_sel_o,
  output logic            dens10_o,
  output logic            double_o,
  output logic [5:0]      fill_o,
  output logic            printing_o,
  output logic            feeding_o
);

  // ---------------------------------------------------------------
  // State of the device.
  // ---------------------------------------------------------------
  typedef enum {PARSE_IDLE, PARSE_DMA_LO, PARSE_DMA_HI, PARSE_ONE} phc_parse_t;
  typedef struct packed {
    logic [2:0]  sync_wr;     // Write strobe synchroniser and edge stage.
    logic [2:0]  sync_ack;    // DMA strobe synchroniser and edge stage.
    logic [1:0]  sync_cs;
    logic [1:0]  sync_rd;
    logic [7:0]  in_byte;     // Input data register.
    logic        full;
    logic        dma_on;
    logic [15:0] dma_left;
    logic        dma_req;
    phc_parse_t  parse;
    logic [7:0]  lo_byte;
    logic [7:0]  par_cmd;
    logic        gp1;
    logic        gp2;
    logic [2:0]  strobe;
    logic        dens10;
    logic        dbl;
    logic [5:0]  fill;
    logic [7:0]  tab1;
    logic [7:0]  tab2;
    logic [7:0]  tab3;
    logic [7:0]  lf_left;
    logic        print;
    logic        feed;
    logic [31:0] busy_cnt;
    logic        req;
    logic [7:0]  dq;
    logic        dq_oe;
  } phc_dev_t;

  phc_dev_t st_reg;
  phc_dev_t st_next;
  logic [5:0] cap;
  logic       wr_edge;
  logic       ack_edge;
  logic       take;

  // Capacity depends on density and width.
  always_comb begin
    case ({st_reg.dens10, st_reg.dbl})
      2'b00:   cap = phc_pkg::CAP_12_SINGLE;
      2'b01:   cap = phc_pkg::CAP_12_DOUBLE;
      2'b10:   cap = phc_pkg::CAP_10_SINGLE;
      default: cap = phc_pkg::CAP_10_DOUBLE;
    endcase
  end

  assign wr_edge  = st_reg.sync_wr[2] & ~st_reg.sync_wr[1] & ~st_reg.sync_cs[1];
  assign ack_edge = ~st_reg.sync_ack[2] & st_reg.sync_ack[1];
  assign take     = st_reg.full & ~st_reg.print & ~st_reg.feed;

  // Next state: synchronise pins, latch bytes, parse commands, run cycles.
  always_comb begin
    st_next = st_reg;
    st_next.sync_wr  = {st_reg.sync_wr[1:0], bus.wr_n};
    st_next.sync_ack = {st_reg.sync_ack[1:0], bus.dma_ack};
    st_next.sync_cs  = {st_reg.sync_cs[0], bus.cs_n};
    st_next.sync_rd  = {st_reg.sync_rd[0], bus.rd_n};
    // Status read drives the bus only, changing no flag.
    st_next.dq_oe = ~st_reg.sync_cs[1] & ~st_reg.sync_rd[1];
    st_next.dq    = 8'h00;
    st_next.dq[phc_pkg::FULL_BIT] = st_reg.full;
    st_next.dq[phc_pkg::DMA_BIT]  = st_reg.dma_on;
    // Mechanical cycle timer.
    if (st_reg.print || st_reg.feed) begin
      if (st_reg.busy_cnt != 32'h0) begin
        st_next.busy_cnt = st_reg.busy_cnt - 32'h1;
      end else if (st_reg.feed && st_reg.lf_left > 8'h1) begin
        st_next.lf_left  = st_reg.lf_left - 8'h1;
        st_next.busy_cnt = 32'(LF_CYC - 1);
      end else begin
        st_next.print = 1'b0;
        st_next.feed  = 1'b0;
      end
    end
    // Host write or DMA byte lands in the input register.
    if (wr_edge && !st_reg.full) begin
      st_next.in_byte = bus.dq_host;
      st_next.full    = 1'b1;
      st_next.req     = 1'b0;
    end else if (ack_edge && st_reg.dma_on && !st_reg.full) begin
      st_next.in_byte  = bus.dq_host;
      st_next.full     = 1'b1;
      st_next.dma_req  = 1'b0;
      st_next.dma_left = st_reg.dma_left - 16'h1;
    end else if (take) begin
      st_next.full = 1'b0;
      case (st_reg.parse)
        PARSE_DMA_LO: begin
          st_next.lo_byte = st_reg.in_byte;
          st_next.parse   = PARSE_DMA_HI;
        end
        PARSE_DMA_HI: begin
          st_next.dma_left = {st_reg.in_byte, st_reg.lo_byte};
          st_next.dma_on   = ({st_reg.in_byte, st_reg.lo_byte} != 16'h0);
          st_next.parse    = PARSE_IDLE;
        end
        PARSE_ONE: begin
          // Any code, a reset code included, is taken as the parameter.
          st_next.parse = PARSE_IDLE;
          case (st_reg.par_cmd)
            phc_pkg::CMD_TAB1:   st_next.tab1 = st_reg.in_byte;
            phc_pkg::CMD_TAB2:   st_next.tab2 = st_reg.in_byte;
            phc_pkg::CMD_TAB3:   st_next.tab3 = st_reg.in_byte;
            phc_pkg::CMD_STROBE: st_next.strobe = st_reg.in_byte[2:0];
            default: begin
              if (st_reg.in_byte != 8'h0) begin
                st_next.feed     = 1'b1;
                st_next.lf_left  = st_reg.in_byte;
                st_next.busy_cnt = 32'(LF_CYC - 1);
              end
            end
          endcase
        end
        default: begin
          case (st_reg.in_byte)
            phc_pkg::CMD_GP1_CLR: st_next.gp1 = 1'b0;
            phc_pkg::CMD_GP2_CLR: st_next.gp2 = 1'b0;
            phc_pkg::CMD_GP1_SET: st_next.gp1 = 1'b1;
            phc_pkg::CMD_GP2_SET: st_next.gp2 = 1'b1;
            phc_pkg::CMD_SW_RESET: begin
              st_next.fill   = 6'h0;
              st_next.dens10 = 1'b0;
              st_next.dbl    = 1'b0;  // Strobe, tabs and outputs stay
            end
            phc_pkg::CMD_DENS_10: begin
              st_next.dens10 = 1'b1;
              st_next.fill   = 6'h0;
            end
            phc_pkg::CMD_DENS_12: begin
              st_next.dens10 = 1'b0;
              st_next.fill   = 6'h0;
            end
            phc_pkg::CMD_DOUBLE: begin
              st_next.dbl  = 1'b1;
              st_next.fill = 6'h0;
            end
            phc_pkg::CMD_DMA_EN:  st_next.parse = PARSE_DMA_LO;
            phc_pkg::CMD_LINE_FEED: begin
              st_next.feed     = 1'b1;
              st_next.lf_left  = 8'h1;
              st_next.busy_cnt = 32'(LF_CYC - 1);
            end
            phc_pkg::CMD_CR: begin
              if (st_reg.fill != 6'h0) begin
                st_next.print    = 1'b1;
                st_next.fill     = 6'h0;
                st_next.busy_cnt = 32'(PRINT_CYC - 1);
              end
            end
            phc_pkg::CMD_MULTI_LF, phc_pkg::CMD_TAB1, phc_pkg::CMD_TAB2,
            phc_pkg::CMD_TAB3, phc_pkg::CMD_STROBE: begin
              st_next.par_cmd = st_reg.in_byte;
              st_next.parse   = PARSE_ONE;
            end
            default: begin
              if (st_reg.in_byte >= phc_pkg::PRINT_LO && st_reg.in_byte <= phc_pkg::PRINT_HI) begin
                if (st_reg.fill + 6'h1 >= cap) begin
                  st_next.print    = 1'b1;
                  st_next.fill     = 6'h0;
                  st_next.busy_cnt = 32'(PRINT_CYC - 1);
                end else begin
                  st_next.fill = st_reg.fill + 6'h1;
                end
              end
            end
          endcase
        end
      endcase
    end
    // DMA block end and fetch requests.
    if (st_reg.dma_on && st_reg.dma_left == 16'h0 && !st_reg.full) begin
      st_next.dma_on = 1'b0;
    end
    if (st_reg.dma_on && st_reg.dma_left == 16'h0 && bus.dma_done) begin
      st_next.dma_on = 1'b0;
    end
    if (st_next.dma_on && !st_next.full && st_next.dma_left != 16'h0 && !ack_edge) begin
      st_next.dma_req = 1'b1;
    end
    // Request shows the port is free for a host byte.
    st_next.req = ~st_next.full & ~st_next.dma_on & ~wr_edge;
  end

  // State register with hardware reset values.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg          <= '0;
      st_reg.sync_wr  <= 3'h7;
      st_reg.sync_cs  <= 2'h3;
      st_reg.sync_rd  <= 2'h3;
      st_reg.parse    <= PARSE_IDLE;
      st_reg.gp1      <= 1'b1;
      st_reg.gp2      <= 1'b1;
      st_reg.strobe   <= phc_pkg::STROBE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.dq_dev     = st_reg.dq;
  assign bus.dq_dev_oe  = st_reg.dq_oe;
  assign bus.req_o_line = st_reg.req;
  assign bus.dma_req    = st_reg.dma_req;
  assign gp1_o          = st_reg.gp1;
  assign gp2_o          = st_reg.gp2;
  assign strobe_sel_o   = st_reg.strobe;
  assign dens10_o       = st_reg.dens10;
  assign double_o       = st_reg.dbl;
  assign fill_o         = st_reg.fill;
  assign printing_o     = st_reg.print;
  assign feeding_o      = st_reg.feed;

endmodule

// ==== verilog/phc_host.sv ====
// Host controller end: Wishbone slave driving the printer port strobes.
`timescale 1ns/1ps
module phc_host #(
  parameter int STROBE_CYC = 4
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  phc_if.host              bus
);

  // ---------------------------------------------------------------
  // State of the host controller.
  // ---------------------------------------------------------------
  typedef enum {HST_IDLE, HST_WRITE, HST_READ} phc_hst_t;
  typedef struct packed {
    phc_hst_t    mode;
    logic [7:0]  cnt;
    logic [7:0]  dq;
    logic        oe;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic [7:0]  status;
    logic [15:0] dma_addr;
    logic        dma_ack;
    logic        ack;
    logic [31:0] dat;
    logic [1:0]  s_req;
    logic [1:0]  s_dreq;
    logic [7:0]  s_dq0;
    logic [7:0]  s_dq1;
  } phc_hs_t;

  phc_hs_t hs_reg;
  phc_hs_t hs_next;
  logic    req_new;

  assign req_new = wb_cyc_i & wb_stb_i & ~hs_reg.ack & (hs_reg.mode == HST_IDLE);

  // Next state: run one strobe cycle per data write or status read, serve DMA requests.
  always_comb begin
    hs_next        = hs_reg;
    hs_next.ack    = 1'b0;
    hs_next.s_req  = {hs_reg.s_req[0], bus.req_o_line};
    hs_next.s_dreq = {hs_reg.s_dreq[0], bus.dma_req};
    hs_next.s_dq0  = bus.dq_dev;
    hs_next.s_dq1  = hs_reg.s_dq0;
    // DMA controller side: one strobe per rising request, in any mode.
    // Acking on the edge never strobes a request twice, and no request is missed during a status read.
    hs_next.dma_ack = hs_reg.s_dreq[0] & ~hs_reg.s_dreq[1];
    if (hs_next.dma_ack) begin
      hs_next.dma_addr = hs_reg.dma_addr + 16'h1;
    end
    case (hs_reg.mode)
      HST_WRITE, HST_READ: begin
        if (hs_reg.cnt != 8'h0) begin
          hs_next.cnt = hs_reg.cnt - 8'h1;
        end else begin
          hs_next.cs_n = 1'b1;
          hs_next.wr_n = 1'b1;
          hs_next.rd_n = 1'b1;
          hs_next.oe   = 1'b0;
          hs_next.mode = HST_IDLE;
          hs_next.ack  = 1'b1;
          if (hs_reg.mode == HST_READ) begin
            hs_next.status = hs_reg.s_dq1;
            hs_next.dat    = {24'h0, hs_reg.s_dq1};
          end
        end
      end
      default: begin
        if (req_new) begin
          hs_next.cnt = 8'(STROBE_CYC);
          hs_next.dat = 32'h0;
          if (wb_adr_i == phc_pkg::CTL_DATA_OFF && wb_we_i) begin
            hs_next.mode = HST_WRITE;
            hs_next.cs_n = 1'b0;
            hs_next.wr_n = 1'b0;
            hs_next.oe   = 1'b1;
            hs_next.dq   = wb_dat_i[7:0];
          end else if (wb_adr_i == phc_pkg::CTL_STAT_OFF && !wb_we_i) begin
            hs_next.mode = HST_READ;
            hs_next.cs_n = 1'b0;
            hs_next.rd_n = 1'b0;
          end else begin
            hs_next.ack = 1'b1;
            if (wb_adr_i == phc_pkg::CTL_DMA_OFF && wb_we_i && wb_sel_i[0]) begin
              hs_next.dma_addr = wb_dat_i[15:0];
            end else if (wb_adr_i == phc_pkg::CTL_DMA_OFF) begin
              hs_next.dat = {16'h0, hs_reg.dma_addr};
            end else if (wb_adr_i == phc_pkg::CTL_DATA_OFF) begin
              hs_next.dat = {23'h0, hs_reg.s_req[1], hs_reg.status};
            end
          end
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hs_reg      <= '0;
      hs_reg.mode <= HST_IDLE;
      hs_reg.cs_n <= 1'b1;
      hs_reg.rd_n <= 1'b1;
      hs_reg.wr_n <= 1'b1;
    end else begin
      hs_reg <= hs_next;
    end
  end

  assign wb_ack_o       = hs_reg.ack;
  assign wb_dat_o       = hs_reg.dat;
  assign bus.cs_n       = hs_reg.cs_n;
  assign bus.rd_n       = hs_reg.rd_n;
  assign bus.wr_n       = hs_reg.wr_n;
  assign bus.dq_host    = hs_reg.dq;
  assign bus.dq_host_oe = hs_reg.oe;
  assign bus.dma_ack    = hs_reg.dma_ack;
  assign bus.dma_done   = 1'b0;

endmodule
